// file: verilog/pit_timer.sv
// module: prescaled 16-bit interval timer with APB register access and interrupt
//
// Behaviour
// - count decrements once every n prescaled cycles
// - reaching zero raises the timer interrupt
// - at zero, count reloads from period register
// - counting runs alongside bus and processor activity
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module pit_timer #(
  parameter int COUNT_W = 16,
  parameter int SCALE_W = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic timerIrq
);
  // ==========================================================
  // declarations
  pit_pkg::pit_bus_state_t busState_q;
  pit_pkg::pit_bus_state_t busState_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic err_q;
  logic err_d;
  logic [COUNT_W-1:0] count_q;
  logic [COUNT_W-1:0] count_d;
  logic [COUNT_W-1:0] period_q;
  logic [COUNT_W-1:0] period_d;
  logic [SCALE_W-1:0] scale_q;
  logic [SCALE_W-1:0] scale_d;
  logic run_q;
  logic run_d;
  logic [pit_pkg::EVT_W-1:0] status_q;
  logic [pit_pkg::EVT_W-1:0] status_d;
  logic [pit_pkg::EVT_W-1:0] intEn_q;
  logic [pit_pkg::EVT_W-1:0] intEn_d;
  logic irq_q;
  logic irq_d;
  logic ready_q;
  logic ready_d;
  logic wrDone;
  logic wrCount;
  logic zeroHit;
  logic [pit_pkg::EVT_W-1:0] evtSet;
  logic [pit_pkg::EVT_W-1:0] evtClr;

  pit_tick_if #(.SCALE_W(SCALE_W)) tickBus ();

  // ==========================================================
  // address decode
  // true when the low address bits select the given register and all higher address bits are zero
  function automatic logic hitReg(input logic [31:0] addr, input logic [4:0] off);
    hitReg = (addr[pit_pkg::ADDR_W-1:0] == off) && (addr[31:pit_pkg::ADDR_W] == '0);
  endfunction

  // true for any implemented register
  function automatic logic mapped(input logic [31:0] addr);
    mapped = hitReg(addr, pit_pkg::OFF_COUNT) || hitReg(addr, pit_pkg::OFF_PRESCALE)
      || hitReg(addr, pit_pkg::OFF_PERIOD) || hitReg(addr, pit_pkg::OFF_STATUS)
      || hitReg(addr, pit_pkg::OFF_INT_ENABLE) || hitReg(addr, pit_pkg::OFF_INT_CLEAR)
      || hitReg(addr, pit_pkg::OFF_CONTROL);
  endfunction

  // ==========================================================
  // APB answer sequencing
  // one wait state: pready rises in the second access cycle
  always_comb begin
    busState_d = busState_q;
    rdata_d = rdata_q;
    err_d = err_q;
    ready_d = 1'b0;
    unique case (busState_q)
      pit_pkg::PIT_BUS_IDLE: begin
        if (psel && penable) begin
          busState_d = pit_pkg::PIT_BUS_ANSWER;
          ready_d = 1'b1;
          err_d = !mapped(paddr);
          rdata_d = '0;
          if (!pwrite) begin
            if (hitReg(paddr, pit_pkg::OFF_COUNT)) begin
              rdata_d[COUNT_W-1:0] = count_q;
            end
            if (hitReg(paddr, pit_pkg::OFF_PRESCALE)) begin
              rdata_d[SCALE_W-1:0] = scale_q;
            end
            if (hitReg(paddr, pit_pkg::OFF_PERIOD)) begin
              rdata_d[COUNT_W-1:0] = period_q;
            end
            if (hitReg(paddr, pit_pkg::OFF_STATUS)) begin
              rdata_d[pit_pkg::EVT_W-1:0] = status_q;
            end
            if (hitReg(paddr, pit_pkg::OFF_INT_ENABLE)) begin
              rdata_d[pit_pkg::EVT_W-1:0] = intEn_q;
            end
            if (hitReg(paddr, pit_pkg::OFF_CONTROL)) begin
              rdata_d[pit_pkg::CTRL_RUN_BIT] = run_q;
            end
          end
        end
      end
      pit_pkg::PIT_BUS_ANSWER: begin
        busState_d = pit_pkg::PIT_BUS_IDLE;
        err_d = 1'b0;
      end
    endcase
  end

  // bus registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busState_q <= pit_pkg::PIT_BUS_IDLE;
      ready_q <= 1'b0;
      rdata_q <= '0;
      err_q <= 1'b0;
    end else begin
      busState_q <= busState_d;
      ready_q <= ready_d;
      rdata_q <= rdata_d;
      err_q <= err_d;
    end
  end

  assign pready = ready_q; // answer pulse straight from its own flop
  assign prdata = rdata_q;
  assign pslverr = err_q;

  // a write takes effect at the edge that samples pready high
  assign wrDone = psel && penable && pwrite && pready;
  assign wrCount = wrDone && hitReg(paddr, pit_pkg::OFF_COUNT);

  // ==========================================================
  // prescaler link
  assign tickBus.run = run_q;
  assign tickBus.scale = scale_q;

  pit_prescaler #(.SCALE_W(SCALE_W)) u_prescaler (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tickBus(tickBus)
  );

  // ==========================================================
  // count and configuration registers
  // a tick at zero is the zero event; reload and flag together
  assign zeroHit = tickBus.tick && (count_q == '0);

  // next values; a software count write wins over the tick
  always_comb begin
    count_d = count_q;
    period_d = period_q;
    scale_d = scale_q;
    run_d = run_q;
    intEn_d = intEn_q;
    if (zeroHit) begin
      count_d = period_q;
    end else if (tickBus.tick) begin
      count_d = count_q - 1'b1;
    end
    if (wrCount) begin
      count_d = pwdata[COUNT_W-1:0];
    end
    if (wrDone && hitReg(paddr, pit_pkg::OFF_PERIOD)) begin
      period_d = pwdata[COUNT_W-1:0];
    end
    if (wrDone && hitReg(paddr, pit_pkg::OFF_PRESCALE)) begin
      scale_d = pwdata[SCALE_W-1:0];
    end
    if (wrDone && hitReg(paddr, pit_pkg::OFF_CONTROL)) begin
      run_d = pwdata[pit_pkg::CTRL_RUN_BIT];
    end
    if (wrDone && hitReg(paddr, pit_pkg::OFF_INT_ENABLE)) begin
      intEn_d = pwdata[pit_pkg::EVT_W-1:0];
    end
  end

  // register stage
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= pit_pkg::COUNT_RST;
      period_q <= pit_pkg::PERIOD_RST;
      scale_q <= pit_pkg::SCALE_RST;
      run_q <= pit_pkg::RUN_RST;
      intEn_q <= pit_pkg::EVT_RST;
    end else begin
      count_q <= count_d;
      period_q <= period_d;
      scale_q <= scale_d;
      run_q <= run_d;
      intEn_q <= intEn_d;
    end
  end

  // ==========================================================
  // interrupt status
  // sticky status; a new event wins over a same-cycle clear
  always_comb begin
    evtSet = '0;
    evtSet[pit_pkg::EVT_ZERO_BIT] = zeroHit;
    evtClr = '0;
    if (wrDone && hitReg(paddr, pit_pkg::OFF_INT_CLEAR)) begin
      evtClr = pwdata[pit_pkg::EVT_W-1:0];
    end
    status_d = (status_q & ~evtClr) | evtSet;
    irq_d = |(status_d & intEn_d);
  end

  // register stage
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= pit_pkg::EVT_RST;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      irq_q <= irq_d;
    end
  end

  assign timerIrq = irq_q;

  // ==========================================================
  // checks
  chk_count_decrement: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (tickBus.tick && count_q != '0 && !wrCount) |=> count_q == $past(count_q) - 1'b1)
    else $error("count did not step down by one on a tick");

  chk_count_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!tickBus.tick && !wrCount) |=> $stable(count_q))
    else $error("count moved without a tick or a write");

  chk_zero_reload: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (zeroHit && !wrCount) |=> count_q == $past(period_q))
    else $error("count not reloaded from period at zero");

  chk_zero_irq: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (zeroHit && intEn_d[pit_pkg::EVT_ZERO_BIT]) |=> status_q[pit_pkg::EVT_ZERO_BIT] && timerIrq)
    else $error("zero event did not raise status and interrupt");

  chk_irq_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
    timerIrq |-> |(status_q & intEn_q))
    else $error("interrupt high without an enabled status bit");

  chk_runs_with_bus: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (psel && tickBus.tick && count_q != '0 && !wrCount) |=> count_q != $past(count_q))
    else $error("count stalled during a bus access");

  chk_bus_answer: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (psel && penable && !pready) |=> pready)
    else $error("bus answer not given one cycle into the access");

  chk_ready_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pready |=> !pready)
    else $error("bus answer stood longer than one cycle");

  chk_error_with_ready: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pslverr |-> pready)
    else $error("bus error shown without the answer");

  // ==========================================================
  // status, interrupt, count, reload and stop checks
  chk_status_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (status_q[pit_pkg::EVT_ZERO_BIT] && !evtClr[pit_pkg::EVT_ZERO_BIT])
      |=> status_q[pit_pkg::EVT_ZERO_BIT])
    else $error("zero event status dropped without a clear");

  chk_event_wins: assert property (@(posedge sys_clk) disable iff (!rst_n)
    zeroHit |=> status_q[pit_pkg::EVT_ZERO_BIT])
    else $error("zero event lost against a clear");

  chk_irq_level: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (|(status_q & intEn_q)) |-> timerIrq)
    else $error("enabled status bit set but interrupt low");

  chk_count_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wrCount |=> count_q == $past(pwdata[COUNT_W-1:0]))
    else $error("count write did not land");

  chk_period_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wrDone && hitReg(paddr, pit_pkg::OFF_PERIOD))
      |=> period_q == $past(pwdata[COUNT_W-1:0]))
    else $error("period write did not land");

  chk_stopped_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !run_q |-> !tickBus.tick)
    else $error("prescaler ticked while the timer was stopped");

  cov_zero_event: cover property (@(posedge sys_clk) disable iff (!rst_n) zeroHit);
  cov_irq_cleared: cover property (@(posedge sys_clk) disable iff (!rst_n)
    timerIrq ##1 !timerIrq);
  cov_write_vs_tick: cover property (@(posedge sys_clk) disable iff (!rst_n)
    wrCount && tickBus.tick);
  cov_bad_address: cover property (@(posedge sys_clk) disable iff (!rst_n) pslverr);
  cov_event_vs_clear: cover property (@(posedge sys_clk) disable iff (!rst_n)
    zeroHit && evtClr[pit_pkg::EVT_ZERO_BIT]);
endmodule
`default_nettype wire

// file: verilog/pit_pkg.sv
// package: register map, field positions and reset values of the interval timer
package pit_pkg;
  // ==========================================================
  // register byte offsets
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFF_COUNT = 5'h00;
  localparam logic [4:0] OFF_PRESCALE = 5'h04;
  localparam logic [4:0] OFF_PERIOD = 5'h08;
  localparam logic [4:0] OFF_STATUS = 5'h0C;
  localparam logic [4:0] OFF_INT_ENABLE = 5'h10;
  localparam logic [4:0] OFF_INT_CLEAR = 5'h14;
  localparam logic [4:0] OFF_CONTROL = 5'h18;

  // ==========================================================
  // widths, fields and reset values
  localparam int COUNT_W = 16;
  localparam int SCALE_W = 8;
  localparam int EVT_W = 1;
  localparam int CTRL_RUN_BIT = 0;
  localparam int EVT_ZERO_BIT = 0;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [7:0] SCALE_RST = 8'h00;
  localparam logic [15:0] PERIOD_RST = 16'h0000;
  localparam logic RUN_RST = 1'b0;
  localparam logic [0:0] EVT_RST = 1'h0;

  // ==========================================================
  // register bus answer states
  typedef enum logic {
    PIT_BUS_IDLE,
    PIT_BUS_ANSWER
  } pit_bus_state_t;
endpackage

// file: verilog/pit_tick_if.sv
// interface: run enable and scale towards the prescaler, decrement tick back
`timescale 1ns/1ps
`default_nettype none
interface pit_tick_if #(
  parameter int SCALE_W = 8
);
  logic run;
  logic [SCALE_W-1:0] scale;
  logic tick;

  modport timer (output run, output scale, input tick);
  modport prescaler (input run, input scale, output tick);
endinterface
`default_nettype wire

// file: verilog/pit_prescaler.sv
// module: 8-bit reloading down-counter that paces the interval timer
`timescale 1ns/1ps
`default_nettype none
module pit_prescaler #(
  parameter int SCALE_W = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  pit_tick_if.prescaler tickBus
);
  logic [SCALE_W-1:0] cnt_q;
  logic [SCALE_W-1:0] cnt_d;

  // ==========================================================
  // prescale counter
  // one tick each time the counter expires; scale zero ticks every cycle
  assign tickBus.tick = tickBus.run && (cnt_q == '0);

  // next value: reload on expiry or while stopped
  always_comb begin
    cnt_d = cnt_q;
    if (!tickBus.run || cnt_q == '0) begin
      cnt_d = tickBus.scale;
    end else begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // register stage
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ==========================================================
  // checks
  chk_prescale_reload: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tickBus.tick |=> cnt_q == $past(tickBus.scale))
    else $error("prescaler did not reload from scale after a tick");

  chk_prescale_gap: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (tickBus.tick && tickBus.scale != '0) ##1 tickBus.run |-> !tickBus.tick)
    else $error("prescaler ticked twice in a row with nonzero scale");
endmodule
`default_nettype wire

// file: sim/pit_timer_test.sv
// testbench: register access, interrupt and event interval checks of the interval timer
`timescale 1ns/1ps
`default_nettype none
module pit_timer_test;
  // ==========================================================
  // stimulus signals and counters
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h00000000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic timerIrq;
  logic [31:0] rd;
  logic err;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  logic [4:0] offs [7];

  pit_timer #(.COUNT_W(16), .SCALE_W(8)) dut (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .timerIrq(timerIrq)
  );

  // 40 MHz clock and a free cycle count for interval timing
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
  end

  // ==========================================================
  // verdict and compare tasks
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask

  // ==========================================================
  // apb master: setup, access until pready, then release
  task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] off, input logic [31:0] data);
    apb(1'b1, {27'h0000000, off}, data);
  endtask

  task automatic rdchk(input string name, input logic [4:0] off, input logic [31:0] exp);
    apb(1'b0, {27'h0000000, off}, 32'h00000000);
    chk_word(name, exp, rd);
    chk_bit({name, " slverr"}, 1'b0, err);
  endtask

  // waits a bounded time for the interrupt, returns the cycle seen
  task automatic wait_irq(output int t);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (timerIrq !== 1'b1 && n < 2000);
    if (timerIrq !== 1'b1) begin
      num_errors++;
      end_sim();
    end
    t = cyc;
  endtask

  // clear the zero event and let the interrupt fall
  task automatic clr();
    wr(pit_pkg::OFF_INT_CLEAR, 32'h00000001);
    repeat (2) @(posedge sys_clk);
  endtask

  // steady spacing of zero events for one scale and period
  task automatic measure(input logic [7:0] scale, input logic [15:0] period);
    int t1;
    int t2;
    wr(pit_pkg::OFF_PRESCALE, {24'h000000, scale});
    wr(pit_pkg::OFF_PERIOD, {16'h0000, period});
    // two events discarded: the first may be stale, the second may miss the clear
    wait_irq(t1);
    clr();
    wait_irq(t1);
    clr();
    wait_irq(t1);
    clr();
    wait_irq(t2);
    clr();
    chk_word("event interval", (32'(period) + 32'h1) * (32'(scale) + 32'h1), 32'(t2 - t1));
  endtask

  // ==========================================================
  // main sequence
  initial begin
    offs = '{pit_pkg::OFF_COUNT, pit_pkg::OFF_PRESCALE, pit_pkg::OFF_PERIOD,
             pit_pkg::OFF_STATUS, pit_pkg::OFF_INT_ENABLE, pit_pkg::OFF_INT_CLEAR,
             pit_pkg::OFF_CONTROL};
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    // every register reads zero after reset
    foreach (offs[i]) begin
      rdchk("reset value", offs[i], 32'h00000000);
    end
    chk_bit("irq after reset", 1'b0, timerIrq);
    // register widths
    wr(pit_pkg::OFF_COUNT, 32'hFFFFFFFF);
    wr(pit_pkg::OFF_PRESCALE, 32'hFFFFFFFF);
    wr(pit_pkg::OFF_PERIOD, 32'hFFFFFFFF);
    rdchk("count width", pit_pkg::OFF_COUNT, 32'h0000FFFF);
    rdchk("prescale width", pit_pkg::OFF_PRESCALE, 32'h000000FF);
    rdchk("period width", pit_pkg::OFF_PERIOD, 32'h0000FFFF);
    // unmapped and out-of-range addresses answer with an error
    apb(1'b1, 32'h0000001C, 32'h00000000);
    chk_bit("unmapped write slverr", 1'b1, err);
    apb(1'b0, 32'h00000020, 32'h00000000);
    chk_bit("high address slverr", 1'b1, err);
    repeat (20) @(posedge sys_clk);
    rdchk("stopped count", pit_pkg::OFF_COUNT, 32'h0000FFFF);
    // zero event while masked, then enabled and cleared
    wr(pit_pkg::OFF_COUNT, 32'h00000000);
    wr(pit_pkg::OFF_PRESCALE, 32'h00000000);
    wr(pit_pkg::OFF_PERIOD, 32'h00000063);
    wr(pit_pkg::OFF_CONTROL, 32'h00000001);
    repeat (4) @(posedge sys_clk);
    rdchk("zero event status", pit_pkg::OFF_STATUS, 32'h00000001);
    chk_bit("masked irq", 1'b0, timerIrq);
    wr(pit_pkg::OFF_INT_ENABLE, 32'h00000001);
    repeat (2) @(posedge sys_clk);
    chk_bit("enabled irq", 1'b1, timerIrq);
    clr();
    chk_bit("cleared irq", 1'b0, timerIrq);
    rdchk("cleared status", pit_pkg::OFF_STATUS, 32'h00000000);
    // reload period and prescale set the event spacing, bus traffic meanwhile
    measure(8'h00, 16'h0009);
    measure(8'h02, 16'h0009);
    measure(8'h05, 16'h0003);
    measure(8'hFF, 16'h0001);
    end_sim();
  end
endmodule
`default_nettype wire
